// [nvdm_consts.vh]
`ifndef NVDM_CONSTS_VH
`define NVDM_CONSTS_VH

// Register offsets
`define NVDM_OFS_CONTROL    8'hCE
`define NVDM_OFS_WDATA      8'hCF
`define NVDM_OFS_ADDR_LOW   8'hC7

// Control fields
`define NVDM_BIT_ERASE      7
`define NVDM_BIT_WRITE      6
`define NVDM_BIT_WINDOW     5

// Reset values
`define NVDM_RST_CONTROL    8'h00
`define NVDM_RST_WDATA      8'h00
`define NVDM_RST_ADDR_LOW   8'h00

// Geometry
`define NVDM_PAGES          8
`define NVDM_PAGE_BYTES     16
`define NVDM_BYTES          128
`define NVDM_AW             7
`define NVDM_ERASED         8'hFF

// Timing
`define NVDM_CLK_NS         10
`define NVDM_ERASE_NS       20000
`define NVDM_WRITE_NS       5000
`define NVDM_ERASE_CYC      ((`NVDM_ERASE_NS + `NVDM_CLK_NS - 1) / `NVDM_CLK_NS)
`define NVDM_WRITE_CYC      ((`NVDM_WRITE_NS + `NVDM_CLK_NS - 1) / `NVDM_CLK_NS)
`define NVDM_TW             12

`endif

// [nvdm_busy_timer.v]
`include "nvdm_consts.vh"

module nvdm_busy_timer (
  // Clock and reset
  input  wire                 clk,
  input  wire                 srst,
  // Control
  input  wire                 load,
  input  wire [`NVDM_TW-1:0]  load_val,
  // Status
  output wire                 running,
  output reg                  done
);

  reg [`NVDM_TW-1:0] cnt_reg;

  assign running = (cnt_reg != {`NVDM_TW{1'b0}});

  // Counts the busy time down and pulses at the last cycle
  always @(posedge clk) begin
    if (srst) begin
      cnt_reg <= {`NVDM_TW{1'b0}};
      done    <= 1'b0;
    end else if (load) begin
      cnt_reg <= load_val;
      done    <= 1'b0;
    end else if (running) begin
      cnt_reg <= cnt_reg - {{(`NVDM_TW-1){1'b0}}, 1'b1};
      done    <= (cnt_reg == {{(`NVDM_TW-1){1'b0}}, 1'b1});
    end else begin
      done <= 1'b0;
    end
  end

endmodule

// [nvdm_cell_array.v]
`include "nvdm_consts.vh"

module nvdm_cell_array (
  // Clock
  input  wire                 clk,
  // Page erase
  input  wire                 erase_en,
  input  wire [2:0]           erase_page,
  // Byte program
  input  wire                 prog_en,
  input  wire [`NVDM_AW-1:0]  prog_addr,
  input  wire [7:0]           prog_data,
  // Read
  input  wire [`NVDM_AW-1:0]  rd_addr,
  output wire [7:0]           rd_data
);

  wire [`NVDM_BYTES*8-1:0] flat;

  genvar i;
  generate
    for (i = 0; i < `NVDM_BYTES; i = i + 1) begin : g_cell
      localparam integer        PAGE_I  = i / `NVDM_PAGE_BYTES;
      localparam integer        ADDR_I  = i;
      localparam [2:0]          PAGE_ID = PAGE_I[2:0];
      localparam [`NVDM_AW-1:0] ADDR_ID = ADDR_I[`NVDM_AW-1:0];
      reg [7:0] cell_reg;
      // One cell; content survives reset
      always @(posedge clk) begin
        if (erase_en && (erase_page == PAGE_ID)) begin
          cell_reg <= `NVDM_ERASED;
        end else if (prog_en && (prog_addr == ADDR_ID)) begin
          cell_reg <= prog_data;
        end
      end
      assign flat[i*8 +: 8] = cell_reg;
    end
  endgenerate

  assign rd_data = flat[rd_addr*8 +: 8];

endmodule

// [nvdm_ctrl.v]
`include "nvdm_consts.vh"

module nvdm_ctrl (
  // Clock and reset
  input  wire         clk,
  input  wire         srst,
  // Special function register access
  input  wire [7:0]   sfr_addr,
  input  wire         sfr_wr,
  input  wire         sfr_rd,
  input  wire [7:0]   sfr_wdata,
  output reg  [7:0]   sfr_rdata,
  output wire         sfr_hit,
  // Instruction flow
  output wire         fetch_stall,
  // External data reads
  input  wire         movx_rd,
  input  wire [15:0]  movx_addr,
  output wire         nv_rd_sel,
  output wire         xram_enable,
  // Program-memory read path
  input  wire         movc_nv_rd,
  input  wire [6:0]   movc_addr,
  // Read answer
  output reg  [7:0]   nv_rd_data,
  output reg          nv_rd_valid,
  // Status
  output wire         nv_busy,
  output reg          nv_op_done
);

  localparam [1:0] ST_IDLE  = 2'b00;
  localparam [1:0] ST_ERASE = 2'b01;
  localparam [1:0] ST_WRITE = 2'b10;

  // Timer is loaded one short, so busy lasts exactly the stated count
  localparam integer        ERASE_LD_I = `NVDM_ERASE_CYC - 1;
  localparam integer        WRITE_LD_I = `NVDM_WRITE_CYC - 1;
  localparam [`NVDM_TW-1:0] ERASE_CYC  = ERASE_LD_I[`NVDM_TW-1:0];
  localparam [`NVDM_TW-1:0] WRITE_CYC  = WRITE_LD_I[`NVDM_TW-1:0];
  localparam [7:0]          RST_CTL    = `NVDM_RST_CONTROL;

  // Register state
  reg [1:0]               state_reg;
  reg [1:0]               state_next;
  reg                     erase_bit_reg;
  reg                     write_bit_reg;
  reg                     window_reg;
  reg [7:0]               wdata_reg;
  reg [7:0]               addr_low_reg;
  reg [2:0]               page_reg;
  reg                     page_armed_reg;
  reg [`NVDM_AW-1:0]      prog_addr_reg;
  reg [7:0]               prog_data_reg;

  // Decoded accesses
  wire                    hit_control;
  wire                    hit_wdata;
  wire                    hit_addr_low;
  wire                    wr_control;
  wire                    start_erase;
  wire                    start_write;

  // Timer and array links
  reg                     tmr_load;
  reg  [`NVDM_TW-1:0]     tmr_val;
  wire                    tmr_running;
  wire                    tmr_done;
  wire                    erase_fire;
  wire                    prog_fire;
  wire                    rd_req;
  wire [`NVDM_AW-1:0]     rd_addr;
  wire [7:0]              arr_rd_data;

  // Address decode
  assign hit_control  = (sfr_addr == `NVDM_OFS_CONTROL);
  assign hit_wdata    = (sfr_addr == `NVDM_OFS_WDATA);
  assign hit_addr_low = (sfr_addr == `NVDM_OFS_ADDR_LOW);
  assign sfr_hit      = hit_control | hit_wdata | hit_addr_low;

  // Control writes are taken only while idle
  assign wr_control  = sfr_wr & hit_control & (state_reg == ST_IDLE);
  assign start_erase = wr_control & sfr_wdata[`NVDM_BIT_ERASE];
  assign start_write = wr_control & ~sfr_wdata[`NVDM_BIT_ERASE]
                       & sfr_wdata[`NVDM_BIT_WRITE];

  // Fetch is held from the starting write until the operation ends
  assign fetch_stall = (state_reg != ST_IDLE) | start_erase | start_write;
  assign nv_busy     = (state_reg != ST_IDLE);

  // Read window steering
  assign nv_rd_sel   = movx_rd & window_reg;
  assign xram_enable = ~window_reg;
  assign rd_req      = nv_rd_sel | movc_nv_rd;
  assign rd_addr     = movc_nv_rd ? movc_addr : movx_addr[`NVDM_AW-1:0];

  // Operation ends on the timer pulse
  assign erase_fire = (state_reg == ST_ERASE) & tmr_done & page_armed_reg;
  assign prog_fire  = (state_reg == ST_WRITE) & tmr_done;

  // Next-state logic
  always @* begin
    state_next = state_reg;
    tmr_load   = 1'b0;
    tmr_val    = {`NVDM_TW{1'b0}};
    case (state_reg)
      ST_IDLE: begin
        if (start_erase) begin
          state_next = ST_ERASE;
          tmr_load   = 1'b1;
          tmr_val    = ERASE_CYC;
        end else if (start_write) begin
          state_next = ST_WRITE;
          tmr_load   = 1'b1;
          tmr_val    = WRITE_CYC;
        end
      end
      ST_ERASE: begin
        if (tmr_done) begin
          state_next = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (tmr_done) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Control register
  always @(posedge clk) begin
    if (srst) begin
      erase_bit_reg <= RST_CTL[`NVDM_BIT_ERASE];
      write_bit_reg <= RST_CTL[`NVDM_BIT_WRITE];
      window_reg    <= RST_CTL[`NVDM_BIT_WINDOW];
    end else begin
      if (wr_control) begin
        erase_bit_reg <= sfr_wdata[`NVDM_BIT_ERASE];
        write_bit_reg <= sfr_wdata[`NVDM_BIT_WRITE] & ~sfr_wdata[`NVDM_BIT_ERASE];
        window_reg    <= sfr_wdata[`NVDM_BIT_WINDOW];
      end else if (tmr_done && (state_reg != ST_IDLE)) begin
        erase_bit_reg <= 1'b0;
        write_bit_reg <= 1'b0;
      end
    end
  end

  // Write data holding register
  always @(posedge clk) begin
    if (srst) begin
      wdata_reg <= `NVDM_RST_WDATA;
    end else if (sfr_wr && hit_wdata && (state_reg == ST_IDLE)) begin
      wdata_reg <= sfr_wdata;
    end
  end

  // Address register selects and arms the page
  always @(posedge clk) begin
    if (srst) begin
      addr_low_reg   <= `NVDM_RST_ADDR_LOW;
      page_reg       <= 3'b000;
      page_armed_reg <= 1'b0;
    end else if (sfr_wr && hit_addr_low && (state_reg == ST_IDLE)) begin
      addr_low_reg   <= sfr_wdata;
      page_reg       <= sfr_wdata[6:4];
      page_armed_reg <= 1'b1;
    end else if (erase_fire) begin
      page_armed_reg <= 1'b0;
    end
  end

  // Byte and address latched as the write starts
  always @(posedge clk) begin
    if (srst) begin
      prog_addr_reg <= {`NVDM_AW{1'b0}};
      prog_data_reg <= 8'h00;
    end else if (start_write) begin
      prog_addr_reg <= addr_low_reg[`NVDM_AW-1:0];
      prog_data_reg <= wdata_reg;
    end
  end

  // Register readback
  always @(posedge clk) begin
    if (srst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      if (hit_control) begin
        sfr_rdata <= {erase_bit_reg, write_bit_reg, window_reg, 5'b00000};
      end else if (hit_wdata) begin
        sfr_rdata <= wdata_reg;
      end else if (hit_addr_low) begin
        sfr_rdata <= addr_low_reg;
      end else begin
        sfr_rdata <= 8'h00;
      end
    end
  end

  // Read answer one cycle after the request
  always @(posedge clk) begin
    if (srst) begin
      nv_rd_data  <= 8'h00;
      nv_rd_valid <= 1'b0;
    end else begin
      nv_rd_valid <= rd_req;
      if (rd_req) begin
        nv_rd_data <= arr_rd_data;
      end
    end
  end

  // Completion pulse
  always @(posedge clk) begin
    if (srst) begin
      nv_op_done <= 1'b0;
    end else begin
      nv_op_done <= tmr_done & (state_reg != ST_IDLE);
    end
  end

  nvdm_busy_timer u_timer (
    .clk      (clk),
    .srst     (srst),
    .load     (tmr_load),
    .load_val (tmr_val),
    .running  (tmr_running),
    .done     (tmr_done)
  );

  nvdm_cell_array u_array (
    .clk        (clk),
    .erase_en   (erase_fire),
    .erase_page (page_reg),
    .prog_en    (prog_fire),
    .prog_addr  (prog_addr_reg),
    .prog_data  (prog_data_reg),
    .rd_addr    (rd_addr),
    .rd_data    (arr_rd_data)
  );

endmodule

// [nvdm_ctrl_checker.sv]
`include "nvdm_consts.vh"
module nvdm_ctrl_checker (
  // Clock and reset
  input wire logic       clk,
  input wire logic       srst,
  // Register access
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // Flow and reads
  input wire logic       fetch_stall,
  input wire logic       movx_rd,
  input wire logic       nv_rd_sel,
  input wire logic       xram_enable,
  input wire logic       movc_nv_rd,
  input wire logic       nv_rd_valid,
  input wire logic       nv_busy,
  input wire logic       nv_op_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Control write accepted while idle
  sequence s_ctl_wr;
    sfr_wr && sfr_addr == `NVDM_OFS_CONTROL && !nv_busy;
  endsequence
  sequence s_done;
    ##[0:1] nv_op_done ##1 !nv_op_done;
  endsequence
  a_erase_start: assert property (s_ctl_wr ##0 sfr_wdata[7] |=> nv_busy)
    else $error("erase did not start");
  a_write_start: assert property (s_ctl_wr ##0 sfr_wdata[6] |=> nv_busy)
    else $error("write did not start");
  a_idle_stays: assert property (s_ctl_wr ##0 sfr_wdata[7:6] == 2'h0 |=> !nv_busy)
    else $error("operation without trigger bit");
  a_stall_busy: assert property (nv_busy |-> fetch_stall)
    else $error("fetch not held while busy");
  a_busy_holds: assert property ($rose(nv_busy) |-> nv_busy [*8])
    else $error("operation ended too early");
  a_done_pulse: assert property ($fell(nv_busy) |-> s_done)
    else $error("no single done pulse at end");
  a_window_route: assert property (nv_rd_sel == (movx_rd && !xram_enable))
    else $error("read window routing wrong");
  a_window_set: assert property (s_ctl_wr |=> xram_enable == !$past(sfr_wdata[5]))
    else $error("window bit not applied");
  a_read_answer: assert property ((movc_nv_rd || nv_rd_sel) |=> nv_rd_valid)
    else $error("read not answered");
  a_no_stray_read: assert property (nv_rd_valid |-> $past(movc_nv_rd) || $past(nv_rd_sel))
    else $error("read answer without request");
  a_reserved_zero: assert property (sfr_rd && sfr_addr == `NVDM_OFS_CONTROL
    |=> sfr_rdata[4:0] == 5'h0)
    else $error("reserved control bits not zero");
endmodule
bind nvdm_ctrl nvdm_ctrl_checker u_nvdm_ctrl_checker (.clk, .srst, .sfr_addr, .sfr_wr,
  .sfr_rd, .sfr_wdata, .sfr_rdata, .fetch_stall, .movx_rd, .nv_rd_sel, .xram_enable,
  .movc_nv_rd, .nv_rd_valid, .nv_busy, .nv_op_done);

// [nvdm_core_model.sv]
module nvdm_core_model (
  // Clock and reset
  input wire logic   clk,
  input wire logic   srst,
  // Hold from the memory
  input wire logic   fetch_stall,
  // Program counter
  output logic [15:0] pc_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  // Counter advances only while fetch is allowed
  always @(posedge clk) begin
    if (srst)
      pc_reg <= 16'h0000;
    else if (!fetch_stall)
      pc_reg <= pc_reg + 16'h0001;
  end
endmodule

// [nvdm_ctrl_tb.sv]
`include "nvdm_consts.vh"
module nvdm_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, srst, sfr_wr, sfr_rd, movx_rd, movc_nv_rd;
  logic [7:0]  sfr_addr, sfr_wdata;
  logic [15:0] movx_addr;
  logic [6:0]  movc_addr;
  wire  [7:0]  sfr_rdata, nv_rd_data;
  wire         sfr_hit, fetch_stall, nv_rd_sel, xram_enable, nv_rd_valid, nv_busy, nv_op_done;
  wire  [15:0] pc_reg;
  int          miscompares = 0;
  int          samples_checked = 0;
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
  nvdm_ctrl u_nvdm_ctrl (.clk, .srst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .sfr_hit, .fetch_stall, .movx_rd, .movx_addr, .nv_rd_sel, .xram_enable, .movc_nv_rd,
    .movc_addr, .nv_rd_data, .nv_rd_valid, .nv_busy, .nv_op_done);
  nvdm_core_model u_nvdm_core_model (.clk, .srst, .fetch_stall, .pc_reg);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1 sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clk) #1 sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) #1 sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clk) #1 sfr_rd = 1'b0;
    `CHK(sfr_rdata, e)
  endtask
  task automatic nvrd(input logic [6:0] a, input logic [7:0] e);
    @(posedge clk) #1 movc_addr = a;
    movc_nv_rd = 1'b1;
    @(posedge clk) #1 movc_nv_rd = 1'b0;
    `CHK(nv_rd_valid, 1'b1)
    `CHK(nv_rd_data, e)
  endtask
  task automatic mx(input logic on);
    @(posedge clk) #1 movx_addr = 16'h0045;
    movx_rd = 1'b1;
    #1 `CHK(nv_rd_sel, on)
    `CHK(xram_enable, !on)
    @(posedge clk) #1 movx_rd = 1'b0;
    `CHK(nv_rd_valid, on)
    if (on) `CHK(nv_rd_data, 8'hA5)
  endtask
  // Start an operation, count busy cycles, check the core stayed frozen
  task automatic op(input logic [7:0] a, d, ctl, input int cyc);
    int          n;
    logic [15:0] pc0;
    wr(`NVDM_OFS_ADDR_LOW, a);
    wr(`NVDM_OFS_WDATA, d);
    wr(`NVDM_OFS_CONTROL, ctl);
    pc0 = pc_reg;
    n = 0;
    while (nv_busy === 1'b1 && n < 3000)
      @(posedge clk) #1 n++;
    `CHK(n, cyc)
    `CHK(pc_reg, pc0)
    `CHK(nv_op_done, 1'b1)
    rd(`NVDM_OFS_CONTROL, ctl & 8'h20);
    `CHK(pc_reg, pc0 + 16'h0002)
  endtask
  task automatic t_reset_values;
    rd(`NVDM_OFS_CONTROL, `NVDM_RST_CONTROL);
    rd(`NVDM_OFS_WDATA, `NVDM_RST_WDATA);
    `CHK(xram_enable, 1'b1)
  endtask
  task automatic t_write_byte;
    op(8'h45, 8'hA5, 8'h40, `NVDM_WRITE_CYC);
    rd(`NVDM_OFS_WDATA, 8'hA5);
    nvrd(7'h45, 8'hA5);
  endtask
  task automatic t_idle_ctrl;
    wr(`NVDM_OFS_WDATA, 8'h5A);
    wr(`NVDM_OFS_CONTROL, 8'h1F);
    `CHK(nv_busy, 1'b0)
    rd(`NVDM_OFS_CONTROL, 8'h00);
    nvrd(7'h45, 8'hA5);
  endtask
  task automatic t_window;
    wr(`NVDM_OFS_CONTROL, 8'h20);
    rd(`NVDM_OFS_CONTROL, 8'h20);
    mx(1'b1);
    wr(`NVDM_OFS_CONTROL, 8'h00);
    mx(1'b0);
  endtask
  task automatic t_erase;
    op(8'h35, 8'h11, 8'h40, `NVDM_WRITE_CYC);
    op(8'h30, 8'h00, 8'h80, `NVDM_ERASE_CYC);
    nvrd(7'h35, `NVDM_ERASED);
    nvrd(7'h3F, `NVDM_ERASED);
    nvrd(7'h45, 8'hA5);
  endtask
  // Erase with no fresh page pick, both trigger bits, data write refused while busy
  task automatic t_unarmed;
    int n;
    wr(`NVDM_OFS_WDATA, 8'h22);
    wr(`NVDM_OFS_CONTROL, 8'h40);
    repeat (`NVDM_WRITE_CYC + 2) @(posedge clk);
    #1 `CHK(nv_busy, 1'b0)
    wr(`NVDM_OFS_CONTROL, 8'hC0);
    rd(`NVDM_OFS_CONTROL, 8'h80);
    wr(`NVDM_OFS_WDATA, 8'h77);
    n = 0;
    while (nv_busy === 1'b1 && n < 3000)
      @(posedge clk) #1 n++;
    `CHK(n, `NVDM_ERASE_CYC - 4)
    rd(`NVDM_OFS_WDATA, 8'h22);
    nvrd(7'h30, 8'h22);
    rd(`NVDM_OFS_ADDR_LOW, 8'h30);
    `CHK(sfr_hit, 1'b1)
    rd(8'hC8, 8'h00);
    `CHK(sfr_hit, 1'b0)
  endtask
  task automatic complete_run;
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    srst = 1'b1;
    {sfr_wr, sfr_rd, movx_rd, movc_nv_rd} = 4'h0;
    {sfr_addr, sfr_wdata, movx_addr} = 32'h0000_0000;
    movc_addr = 7'h00;
    repeat (5) @(posedge clk);
    #1 srst = 1'b0;
    t_reset_values();
    t_write_byte();
    t_idle_ctrl();
    t_window();
    t_erase();
    t_unarmed();
    complete_run();
  end
  initial begin
    #100000;
    miscompares++;
    complete_run();
  end
endmodule
